// file: hdl/mft_tx.v
`include "mft_defines.vh"
// ==========================================================
// Manchester frame transmitter top
module mft_tx #(
    parameter HALF_CYC = `MFT_HALF_CYC,
    parameter DEPTH    = 8
) (
    input  wire       mclk_i,      // 40 MHz clock
    input  wire       rst_b_i,     // Async reset, low
    input  wire       tx_valid_i,  // Payload byte offered
    output reg        tx_ready_o,  // FIFO can take a byte
    input  wire [7:0] tx_data_i,   // Payload byte
    input  wire       par_odd_i,   // 1: odd parity, 0: even
    input  wire       msb_first_i, // 1: MSB first, 0: LSB first
    input  wire       man_inv_i,   // 1: one coded low-high
    output reg        line_o,      // Coded serial output pin
    output reg        busy_o       // Frame in progress
);
    // ======================================================
    // Reset synchroniser
    reg rs1_q;
    reg rs2_q;
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end

    // ======================================================
    // FIFO in the payload path
    wire       f_wready;
    wire       f_rvalid;
    wire [7:0] f_rdata;
    reg        pop_q;
    mft_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(3)) u_fifo (
        .clk_i    (mclk_i),
        .rst_b_i  (rs2_q),
        .wvalid_i (tx_valid_i && tx_ready_o),
        .wready_o (f_wready),
        .wdata_i  (tx_data_i),
        .rvalid_o (f_rvalid),
        .rready_i (pop_q),
        .rdata_o  (f_rdata)
    );

    // Ready registered; one-cycle lag is safe since push also checks full
    always @(posedge mclk_i or negedge rs2_q) begin
        if (!rs2_q) begin
            tx_ready_o <= 1'b0;
        end else begin
            tx_ready_o <= f_wready && !(tx_valid_i && tx_ready_o);
        end
    end

    // ======================================================
    // Half-cell divider gives the half enable for both mid-cell and cell edges
    // Last divider count, cut to the counter width on purpose
    localparam integer HALF_LAST_I = HALF_CYC - 1;
    localparam [15:0]  HALF_LAST   = HALF_LAST_I[15:0];
    reg [15:0] div_q;
    wire       half_en = (div_q == HALF_LAST);
    always @(posedge mclk_i or negedge rs2_q) begin
        if (!rs2_q) begin
            div_q <= 16'h0000;
        end else if (half_en) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001; // RULE8
        end
    end

    // ======================================================
    // Frame builder
    function [7:0] bitrev;
        input [7:0] v;
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                bitrev[k] = v[7-k];
            end
        end
    endfunction

    // Frame image, cell 0 sent first, LSB of the vector
    wire [7:0]  dat  = msb_first_i ? bitrev(f_rdata) : f_rdata; // RULE8
    wire        par  = (^f_rdata) ^ par_odd_i; // RULE5
    wire [16:0] img  = {3'h7, 1'b1, par, dat, 1'b0, 3'h7}; // RULE1 RULE3 RULE4 RULE6

    reg [1:0]  st_q;
    reg [16:0] sh_q;
    reg [4:0]  cnt_q;
    reg        half_q;

    // One frame per FIFO word; cells step on every second half enable
    always @(posedge mclk_i or negedge rs2_q) begin
        if (!rs2_q) begin
            st_q   <= `MFT_ST_IDLE;
            sh_q   <= 17'h1FFFF;
            cnt_q  <= 5'h00;
            half_q <= 1'b0;
            pop_q  <= 1'b0;
            busy_o <= 1'b0;
            line_o <= 1'b0;
        end else begin
            pop_q <= 1'b0;
            case (st_q)
                `MFT_ST_IDLE: begin
                    // Line rests low between frames: no cells, no edges
                    line_o <= 1'b0;
                    if (f_rvalid && !pop_q && half_en) begin
                        sh_q   <= img;
                        pop_q  <= 1'b1;
                        cnt_q  <= 5'h00;
                        half_q <= 1'b0;
                        busy_o <= 1'b1;
                        st_q   <= `MFT_ST_SEND;
                        line_o <= img[0] ^ man_inv_i; // RULE2
                    end
                end
                `MFT_ST_SEND: begin
                    if (half_en) begin
                        if (!half_q) begin
                            half_q <= 1'b1;
                            line_o <= ~(sh_q[0] ^ man_inv_i); // RULE8
                        end else if (cnt_q == `MFT_FRAME_CELLS - 5'h01) begin
                            busy_o <= 1'b0;
                            line_o <= 1'b0;
                            st_q   <= `MFT_ST_IDLE;
                        end else begin
                            half_q <= 1'b0;
                            cnt_q  <= cnt_q + 5'h01;
                            sh_q   <= {1'b1, sh_q[16:1]};
                            line_o <= sh_q[1] ^ man_inv_i; // RULE2
                        end
                    end
                end
                default: begin
                    st_q <= `MFT_ST_IDLE;
                end
            endcase
        end
    end
endmodule

// file: hdl/mft_defines.vh
// Operation
// RULE1: Each payload byte is wrapped in a frame and the whole frame is sent Manchester coded.
// RULE2: The coded stream leaves on one plain output pin, cell after cell, with no clock line.
// RULE3: Three idle cells of value one go out before each frame.
// RULE4: A start cell of value zero follows, then exactly eight payload bits.
// RULE5: One parity cell over the payload comes next, then one stop cell of value one.
// RULE6: Three more idle cells of value one close each frame.
// RULE7: The receiver finds edges, recovers the coded bits and extracts the payload. No receiver here; the test model returns only cell values.
// RULE8: Each cell lasts a fixed divider period with a mid-cell transition; parity sense and bit order are selectable.
`ifndef MFT_DEFINES_VH
`define MFT_DEFINES_VH
// ==========================================================
// Frame layout, cell counts
`define MFT_IDLE_CELLS  4'h3
`define MFT_DATA_BITS   4'h8
`define MFT_FRAME_CELLS 5'h11
// ==========================================================
// Timing: half cell length in clock cycles (40 MHz clock)
`define MFT_CLK_HZ      40000000
`define MFT_CELL_NS     1000
`define MFT_HALF_CYC    ((`MFT_CELL_NS * (`MFT_CLK_HZ / 1000000)) / 2000)
// ==========================================================
// States
`define MFT_ST_IDLE     2'h0
`define MFT_ST_SEND     2'h1
`endif

// file: hdl/mft_fifo.v
`include "mft_defines.vh"
// ==========================================================
// Payload FIFO
module mft_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_i,    // Clock
    input  wire             rst_b_i,  // Synchronised reset, low
    input  wire             wvalid_i, // Write valid
    output wire             wready_o, // Not full
    input  wire [WIDTH-1:0] wdata_i,  // Write data
    output wire             rvalid_o, // Not empty
    input  wire             rready_i, // Read accept
    output wire [WIDTH-1:0] rdata_o   // Head word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wptr_q;
    reg [AW:0]      rptr_q;
    wire            full  = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
    wire            empty = (wptr_q == rptr_q);
    wire            push  = wvalid_i && !full;
    wire            pop   = rready_i && !empty;

    assign wready_o = !full;
    assign rvalid_o = !empty;
    assign rdata_o  = mem[rptr_q[AW-1:0]];

    // Storage has no reset, pointers do
    always @(posedge clk_i) begin
        if (push) begin
            mem[wptr_q[AW-1:0]] <= wdata_i;
        end
    end

    // Pointers carry an extra wrap bit for honest full
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wptr_q <= {(AW+1){1'b0}};
            rptr_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
        end
    end
endmodule

// file: verif/mft_tx_checker.sv
// ==========================================================
// Port checker, assumes a half cell of two clocks
module mft_tx_checker (
    input wire logic mclk_i,     // Clock
    input wire logic rst_b_i,    // Reset, low
    input wire logic tx_valid_i, // Offer
    input wire logic tx_ready_o, // Accept
    input wire logic man_inv_i,  // Coding sense
    input wire logic line_o,     // Pin
    input wire logic busy_o      // Frame
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    logic [6:0] cnt_q; // Clocks into frame
    // Frame clock count; bit 1 is the half index
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            cnt_q <= 7'h00;
        else
            cnt_q <= busy_o ? cnt_q + 7'h01 : 7'h00;
    end
    a_idle_low: assert property (!busy_o |-> !line_o) else $error("pin high out of frame");
    a_frame_len: assert property ($fell(busy_o) |-> cnt_q == 7'h44) else $error("frame length");
    a_lead_idle: assert property (busy_o && cnt_q < 7'h0C |-> line_o == (cnt_q[1] ^ !man_inv_i))
        else $error("lead idle");
    a_start_zero: assert property (busy_o && cnt_q[6:2] == 5'h03 |-> line_o == (cnt_q[1] ^ man_inv_i))
        else $error("start cell");
    a_tail_ones: assert property (busy_o && cnt_q > 7'h33 |-> line_o == (cnt_q[1] ^ !man_inv_i))
        else $error("stop or tail");
    a_mid_cell: assert property (busy_o && cnt_q[1:0] == 2'h2 |-> line_o != $past(line_o))
        else $error("no mid edge");
    a_half_hold: assert property (busy_o && cnt_q[0] |-> $stable(line_o)) else $error("half cut");
    a_take_gap: assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o) else $error("no bubble");
    a_frame_gap: assert property ($fell(busy_o) |=> !busy_o) else $error("no gap");
endmodule

// file: verif/mft_mic_model.sv
// ==========================================================
// Phone side decoder: seeks the first high, then one sample per half cell
module mft_mic_model #(parameter int HALF = 2) (
    input  wire logic        clk_i,   // Clock
    input  wire logic        line_i,  // Pin
    input  wire logic        inv_i,   // Coding sense
    output logic      [16:0] cells_o, // Cell values
    output logic             ok_o,    // Halves differ
    output logic             done_o   // Frame seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [33:0] h;
    // Inverted frames open low, so their first half is taken as low
    initial begin
        done_o = 1'b0;
        forever begin
            do @(posedge clk_i); while (line_i !== 1'b1);
            h[0] = 1'b0;
            for (int i = inv_i; i < 34; i++) begin
                h[i] = line_i;
                repeat (HALF) @(posedge clk_i);
            end
            ok_o = 1'b1;
            for (int i = 0; i < 17; i++) begin
                cells_o[i] = h[2*i] ^ inv_i;
                ok_o &= h[2*i] ^ h[2*i+1];
            end
            done_o = 1'b1;
            @(posedge clk_i);
            done_o = 1'b0;
        end
    end
endmodule

// file: verif/test_manchester_frame_transmitter.sv
module test_manchester_frame_transmitter;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, rst_b_i = 0, tx_valid_i = 0, par_odd_i = 0, msb_first_i = 0, man_inv_i = 0;
    logic [7:0] tx_data_i = 8'h00;
    logic tx_ready_o, line_o, busy_o, done, ok;
    logic [16:0] cells;
    bit took;
    int n_mismatch = 0, num_checks = 0, cyc = 0, n;
    always #12.5 mclk_i = ~mclk_i;
    mft_tx #(.HALF_CYC(2)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i), .par_odd_i(par_odd_i), .msb_first_i(msb_first_i),
        .man_inv_i(man_inv_i), .line_o(line_o), .busy_o(busy_o));
    mft_mic_model #(.HALF(2)) u_mic (.clk_i(mclk_i), .line_i(line_o), .inv_i(man_inv_i), .cells_o(cells),
        .ok_o(ok), .done_o(done));
    // Expected cells: three ones, zero, data, parity, stop and three ones
    function automatic logic [16:0] exp_cells(logic [7:0] d, logic odd, logic msb);
        logic [16:0] c;
        c = 17'h1E007;
        for (int k = 0; k < 8; k++) c[4+k] = msb ? d[7-k] : d[k];
        c[12] = ^d ^ odd;
        return c;
    endfunction
    task automatic chk(string nm, logic [16:0] seen, logic [16:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Valid stays up between calls; the caller lowers it
    task automatic push(logic [7:0] d, int lim);
        tx_data_i = d;
        tx_valid_i = 1'b1;
        took = 0;
        for (int k = 0; k < lim && !took; k++) begin
            @(posedge mclk_i);
            took = tx_ready_o;
        end
        @(negedge mclk_i);
    endtask
    task automatic rx(logic [7:0] d);
        for (int k = 0; k < 300 && !done; k++) @(negedge mclk_i);
        chk("frame seen", done, 1'b1);
        chk("cells", cells, exp_cells(d, par_odd_i, msb_first_i));
        chk("halves", ok, 1'b1);
        @(negedge mclk_i);
    endtask
    // Every parity, order and coding combination, one frame each
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            {par_odd_i, msb_first_i, man_inv_i} = m[2:0];
            push(8'h18 ^ 8'(m * 8'h25), 50);
            tx_valid_i = 1'b0;
            chk("took", took, 1'b1);
            rx(8'h18 ^ 8'(m * 8'h25));
        end
    endtask
    // Fill until refused: eight queued plus one in the shifter, then drain in order
    task automatic t_fill();
        for (n = 0; n < 12; n++) begin
            push(8'hA0 + 8'(n), 8);
            if (!took)
                break;
        end
        tx_valid_i = 1'b0;
        chk("refused", took, 1'b0);
        chk("depth", 17'(n), 17'h00009);
        for (int i = 0; i < n; i++) rx(8'hA0 + 8'(i));
    endtask
    // Reset in mid-frame: outputs drop at once, queued bytes are lost
    task automatic t_reset();
        int busy_cnt;
        busy_cnt = 0;
        push(8'h5A, 8);
        push(8'h3C, 8);
        tx_valid_i = 1'b0;
        repeat (10) @(negedge mclk_i);
        chk("busy before cut", busy_o, 1'b1);
        rst_b_i = 1'b0;
        @(negedge mclk_i);
        chk("busy in reset", busy_o, 1'b0);
        chk("line in reset", line_o, 1'b0);
        chk("ready in reset", tx_ready_o, 1'b0);
        @(negedge mclk_i);
        rst_b_i = 1'b1;
        repeat (100) begin
            @(negedge mclk_i);
            if (busy_o !== 1'b0)
                busy_cnt++;
        end
        chk("queue flushed", 17'(busy_cnt), 17'h00000);
        chk("ready after reset", tx_ready_o, 1'b1);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard, well past the expected run
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        repeat (3) @(negedge mclk_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        t_modes();
        t_fill();
        t_reset();
        final_report();
    end
endmodule
bind mft_tx mft_tx_checker u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .tx_valid_i(tx_valid_i),
    .tx_ready_o(tx_ready_o), .man_inv_i(man_inv_i), .line_o(line_o), .busy_o(busy_o));
